// file: hw/crs_pkg.sv
package crs_pkg;

  // Opcodes and opcode patterns
  localparam logic [7:0] OP_CALL = 8'hcd;
  localparam logic [7:0] OP_RET = 8'hc9;
  localparam logic [7:0] OP_CC_MASK = 8'hc7;
  localparam logic [7:0] OP_CALL_CC = 8'hc4;
  localparam logic [7:0] OP_RET_CC = 8'hc0;
  localparam int unsigned CC_LSB = 3;

  // Bit positions inside the condition bits
  localparam int unsigned FLAG_SIGN = 7;
  localparam int unsigned FLAG_ZERO = 6;
  localparam int unsigned FLAG_PARITY = 2;
  localparam int unsigned FLAG_CARRY = 0;

  // T-state lengths of machine cycles, and the T state that carries the strobe
  localparam logic [2:0] TS_M1 = 3'h4;
  localparam logic [2:0] TS_M1_LONG = 3'h5;
  localparam logic [2:0] TS_MEM = 3'h3;
  localparam logic [2:0] TS_MEM_LONG = 3'h4;
  localparam logic [2:0] TS_STROBE = 3'h1;

  // Whole-instruction T-state totals
  localparam int unsigned TOT_CALL = 17;
  localparam int unsigned TOT_CALL_SKIP = 10;
  localparam int unsigned TOT_RET = 10;
  localparam int unsigned TOT_RET_CC = 11;
  localparam int unsigned TOT_RET_SKIP = 5;

  // Reset values
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [15:0] SP_RESET = 16'hffff;

  typedef enum logic [6:0] {
    CRS_FETCH = 7'b0000001,
    CRS_RD_LO = 7'b0000010,
    CRS_RD_HI = 7'b0000100,
    CRS_PUSH_HI = 7'b0001000,
    CRS_PUSH_LO = 7'b0010000,
    CRS_POP_LO = 7'b0100000,
    CRS_POP_HI = 7'b1000000
  } crs_state_t;

endpackage : crs_pkg

`timescale 1ns/1ps
`default_nettype none

module crs_cond_eval
  import crs_pkg::*;
(
  input wire logic [7:0] cond_flags,
  input wire logic [2:0] condition_field,
  output logic cond_true
);

  logic sel_flag;

  always_comb begin
    case (condition_field[2:1])
      2'h0: sel_flag = cond_flags[FLAG_ZERO];
      2'h1: sel_flag = cond_flags[FLAG_CARRY];
      2'h2: sel_flag = cond_flags[FLAG_PARITY];
      default: sel_flag = cond_flags[FLAG_SIGN];
    endcase
    // Even codes test the flag clear, odd codes test it set
    cond_true = (sel_flag == condition_field[0]);
  end

endmodule // crs_cond_eval

`default_nettype wire

// file: hw/crs_sequencer.sv

`timescale 1ns/1ps
`default_nettype none

module crs_sequencer
  import crs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] cond_flags,
  input wire logic sp_load,
  input wire logic [15:0] sp_value,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] instruction_pointer,
  output logic [15:0] stack_top_pointer,
  output logic insn_end
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  crs_state_t state, next_state;
  logic [2:0] tcnt, next_tcnt;
  logic [7:0] opcode, next_opcode;
  logic [7:0] target_lo, next_target_lo;
  logic [7:0] target_hi, next_target_hi;
  logic cond_ok, next_cond_ok;
  logic [15:0] next_ip, next_sp, next_addr;
  logic [7:0] next_wdata;

  logic [2:0] m_len;
  logic last_t, strobe, cond_now;
  logic is_call, is_ret, is_ret_cc;
  logic [15:0] ip_inc;

  // Condition bits are only ever read here, never written
  crs_cond_eval u_cond (
    .cond_flags(cond_flags),
    .condition_field(opcode[CC_LSB +: 3]),
    .cond_true(cond_now)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode and cycle timing

  always_comb begin
    is_call = (opcode == OP_CALL) || ((opcode & OP_CC_MASK) == OP_CALL_CC);
    is_ret_cc = ((opcode & OP_CC_MASK) == OP_RET_CC);
    is_ret = (opcode == OP_RET);
    ip_inc = instruction_pointer + 16'h0001;
    case (state)
      CRS_FETCH: m_len = is_ret_cc ? TS_M1_LONG : TS_M1;
      CRS_RD_HI: m_len = cond_ok ? TS_MEM_LONG : TS_MEM;
      default: m_len = TS_MEM;
    endcase
    last_t = (tcnt == m_len - 3'h1);
    // Opcode is taken early so the fetch length can stretch for a conditional return
    strobe = (tcnt == TS_STROBE);
    mem_rd = strobe && (state != CRS_PUSH_HI) && (state != CRS_PUSH_LO);
    mem_wr = strobe && ((state == CRS_PUSH_HI) || (state == CRS_PUSH_LO));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_state = state;
    next_tcnt = last_t ? 3'h0 : tcnt + 3'h1;
    next_opcode = opcode;
    next_target_lo = target_lo;
    next_target_hi = target_hi;
    next_cond_ok = cond_ok;
    next_ip = instruction_pointer;
    next_sp = stack_top_pointer;
    next_addr = mem_addr;
    next_wdata = mem_wdata;
    insn_end = 1'b0;

    // Read data captured mid-cycle
    if (strobe) begin
      case (state)
        CRS_FETCH: next_opcode = mem_rdata;
        CRS_RD_LO: next_target_lo = mem_rdata;
        CRS_RD_HI: next_target_hi = mem_rdata;
        CRS_POP_LO: next_ip[7:0] = mem_rdata;
        CRS_POP_HI: next_ip[15:8] = mem_rdata;
        default: next_addr = mem_addr;
      endcase
    end

    // Stack pointer set-up only at the start of a fetch, where it is idle
    if (sp_load && (state == CRS_FETCH) && (tcnt == 3'h0)) begin
      next_sp = sp_value;
    end

    if (last_t) begin
      case (state)
        CRS_FETCH: begin
          next_ip = ip_inc;
          if (is_call) begin
            next_cond_ok = (opcode == OP_CALL) || cond_now;
            next_addr = ip_inc;
            next_state = CRS_RD_LO;
          end else if (is_ret || (is_ret_cc && cond_now)) begin
            next_addr = stack_top_pointer;
            next_state = CRS_POP_LO;
          end else begin
            // Failed return or foreign opcode: one fetch only
            next_addr = ip_inc;
            insn_end = 1'b1;
          end
        end
        CRS_RD_LO: begin
          next_ip = ip_inc;
          next_addr = ip_inc;
          next_state = CRS_RD_HI;
        end
        CRS_RD_HI: begin
          // Operands are read whatever the condition
          next_ip = ip_inc;
          if (cond_ok) begin
            next_sp = stack_top_pointer - 16'h0001;
            next_addr = stack_top_pointer - 16'h0001;
            next_wdata = ip_inc[15:8];
            next_state = CRS_PUSH_HI;
          end else begin
            next_addr = ip_inc;
            next_state = CRS_FETCH;
            insn_end = 1'b1;
          end
        end
        CRS_PUSH_HI: begin
          next_sp = stack_top_pointer - 16'h0001;
          next_addr = stack_top_pointer - 16'h0001;
          next_wdata = instruction_pointer[7:0];
          next_state = CRS_PUSH_LO;
        end
        CRS_PUSH_LO: begin
          next_ip = {target_hi, target_lo};
          next_addr = {target_hi, target_lo};
          next_state = CRS_FETCH;
          insn_end = 1'b1;
        end
        CRS_POP_LO: begin
          next_sp = stack_top_pointer + 16'h0001;
          next_addr = stack_top_pointer + 16'h0001;
          next_state = CRS_POP_HI;
        end
        CRS_POP_HI: begin
          next_sp = stack_top_pointer + 16'h0001;
          next_addr = instruction_pointer;
          next_state = CRS_FETCH;
          insn_end = 1'b1;
        end
        default: begin
          next_state = CRS_FETCH;
          next_addr = instruction_pointer;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= CRS_FETCH;
      tcnt <= 3'h0;
      opcode <= 8'h00;
      target_lo <= 8'h00;
      target_hi <= 8'h00;
      cond_ok <= 1'b0;
      instruction_pointer <= IP_RESET;
      stack_top_pointer <= SP_RESET;
      mem_addr <= IP_RESET;
      mem_wdata <= 8'h00;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
      opcode <= next_opcode;
      target_lo <= next_target_lo;
      target_hi <= next_target_hi;
      cond_ok <= next_cond_ok;
      instruction_pointer <= next_ip;
      stack_top_pointer <= next_sp;
      mem_addr <= next_addr;
      mem_wdata <= next_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [4:0] tstate_count;

  // T states elapsed since the current instruction's fetch began; the first
  // cycle after reset is already fetch T1, so it counts as zero as well
  always_ff @(posedge clk) begin
    if (rst || insn_end) begin
      tstate_count <= 5'h00;
    end else begin
      tstate_count <= tstate_count + 5'h01;
    end
  end

  a_push_hi_byte: assert property (@(posedge clk) disable iff (rst)
    (mem_wr && state == CRS_PUSH_HI) |->
      (mem_addr == stack_top_pointer) && (mem_wdata == instruction_pointer[15:8]))
    else $error("high byte push wrong address or data");

  a_push_lo_next: assert property (@(posedge clk) disable iff (rst)
    (state == CRS_PUSH_HI && last_t) |=>
      (state == CRS_PUSH_LO) && (mem_addr == $past(mem_addr) - 16'h0001)
      && (mem_wdata == $past(instruction_pointer[7:0])))
    else $error("low byte push not one below high byte");

  a_target_load: assert property (@(posedge clk) disable iff (rst)
    (state == CRS_PUSH_LO && last_t) |=>
      (instruction_pointer == {$past(target_hi), $past(target_lo)})
      && (mem_addr == instruction_pointer) && (state == CRS_FETCH))
    else $error("call target not loaded or fetched");

  a_call_length: assert property (@(posedge clk) disable iff (rst)
    (insn_end && state == CRS_PUSH_LO) |-> (tstate_count == 5'(TOT_CALL - 1)))
    else $error("taken call length wrong");

  a_call_skip: assert property (@(posedge clk) disable iff (rst)
    (insn_end && state == CRS_RD_HI) |->
      !cond_ok && (tstate_count == 5'(TOT_CALL_SKIP - 1))
      ##1 (instruction_pointer == $past(instruction_pointer) + 16'h0001) && !mem_wr)
    else $error("failed call length or ip step wrong");

  a_ret_length: assert property (@(posedge clk) disable iff (rst)
    (insn_end && state == CRS_POP_HI) |->
      (tstate_count == 5'(is_ret ? TOT_RET - 1 : TOT_RET_CC - 1)))
    else $error("return length wrong");

  a_pop_step: assert property (@(posedge clk) disable iff (rst)
    (state == CRS_POP_LO && last_t) |=>
      (mem_addr == $past(stack_top_pointer) + 16'h0001) ##3
      (stack_top_pointer == $past(stack_top_pointer, 4) + 16'h0002))
    else $error("return did not step stack pointer twice");

  a_ret_skip: assert property (@(posedge clk) disable iff (rst)
    (insn_end && state == CRS_FETCH && is_ret_cc) |->
      (tstate_count == 5'(TOT_RET_SKIP - 1)) && !cond_now
      ##1 (stack_top_pointer == $past(stack_top_pointer)))
    else $error("failed return length or stack wrong");

  a_cond_call: assert property (@(posedge clk) disable iff (rst)
    (state == CRS_FETCH && last_t && (opcode & OP_CC_MASK) == OP_CALL_CC) |=>
      (state == CRS_RD_LO) && (cond_ok == $past(cond_now)))
    else $error("conditional call decode wrong");

  // Address and pointer bookkeeping across the machine cycles
  a_call_first_push: assert property (@(posedge clk) disable iff (rst)
    (state == CRS_RD_HI && last_t && cond_ok) |=>
      (state == CRS_PUSH_HI) && (stack_top_pointer == $past(stack_top_pointer) - 16'h0001))
    else $error("taken call did not start push one below stack top");

  a_operand_addr: assert property (@(posedge clk) disable iff (rst)
    (mem_rd && (state == CRS_RD_LO || state == CRS_RD_HI)) |->
      (mem_addr == instruction_pointer))
    else $error("operand byte read from wrong address");

  a_pop_addr: assert property (@(posedge clk) disable iff (rst)
    (mem_rd && (state == CRS_POP_LO || state == CRS_POP_HI)) |->
      (mem_addr == stack_top_pointer))
    else $error("pop read not at stack top");

  a_ret_resume: assert property (@(posedge clk) disable iff (rst)
    (state == CRS_POP_HI && last_t) |=>
      (state == CRS_FETCH) && (mem_addr == instruction_pointer))
    else $error("return did not fetch from popped pointer");

  a_ret_skip_ip: assert property (@(posedge clk) disable iff (rst)
    (insn_end && state == CRS_FETCH && is_ret_cc) |=>
      (instruction_pointer == $past(instruction_pointer) + 16'h0001)
      && (mem_addr == instruction_pointer))
    else $error("failed return did not step to next instruction");

  a_no_stray_write: assert property (@(posedge clk) disable iff (rst)
    mem_wr |-> (state == CRS_PUSH_HI || state == CRS_PUSH_LO) && cond_ok)
    else $error("memory written outside a taken call push");

  a_call_skip_sp: assert property (@(posedge clk) disable iff (rst)
    (insn_end && state == CRS_RD_HI) |=>
      (stack_top_pointer == $past(stack_top_pointer)))
    else $error("failed call moved the stack pointer");

  a_cond_ret_pop: assert property (@(posedge clk) disable iff (rst)
    (state == CRS_FETCH && last_t && is_ret_cc && cond_now) |=>
      (state == CRS_POP_LO) && (mem_addr == $past(stack_top_pointer)))
    else $error("taken conditional return did not start pop");

endmodule // crs_sequencer

`default_nettype wire

// file: sim/call_return_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none

module call_return_sequencer_test
  import crs_pkg::*;
;
  logic clk, rst, sp_load, mem_rd, mem_wr, insn_end;
  logic [7:0] cond_flags, mem_rdata, mem_wdata;
  logic [15:0] sp_value, mem_addr, instruction_pointer, stack_top_pointer, pc, ra, tg;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  crs_sequencer i_crs_sequencer (.clk(clk), .rst(rst), .cond_flags(cond_flags),
    .sp_load(sp_load), .sp_value(sp_value), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .instruction_pointer(instruction_pointer), .stack_top_pointer(stack_top_pointer),
    .insn_end(insn_end));
  crs_mem_model i_crs_mem_model (.clk(clk), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Every other flag bit holds the opposite value, so a wrong bit select shows
  function automatic logic [7:0] cflags(input logic [2:0] cc, input logic want);
    logic [7:0] f;
    logic b;
    b = want ? cc[0] : ~cc[0];
    f = {8{~b}};
    case (cc[2:1])
      2'h0: f[FLAG_ZERO] = b;
      2'h1: f[FLAG_CARRY] = b;
      2'h2: f[FLAG_PARITY] = b;
      default: f[FLAG_SIGN] = b;
    endcase
    return f;
  endfunction

  // Places one instruction at pc, runs it, checks length and resulting pointers
  task automatic run(input logic [7:0] f, input logic [7:0] b0, b1, b2, input int t_exp,
      input logic [15:0] ip_exp, sp_exp);
    int n;
    i_crs_mem_model.mem[pc] = b0;
    i_crs_mem_model.mem[pc + 16'h0001] = b1;
    i_crs_mem_model.mem[pc + 16'h0002] = b2;
    cond_flags <= f;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (insn_end !== 1'b1 && n < 40);
    check("t_states", 16'(t_exp), 16'(n));
    @(posedge clk);
    #1;
    check("ip", ip_exp, instruction_pointer);
    check("sp", sp_exp, stack_top_pointer);
    pc = ip_exp;
  endtask

  task automatic check_stack(input logic [15:0] sp, input logic [15:0] ret);
    check("stack_lo", {8'h00, ret[7:0]}, {8'h00, i_crs_mem_model.mem[sp]});
    check("stack_hi", {8'h00, ret[15:8]}, {8'h00, i_crs_mem_model.mem[sp + 16'h0001]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    rst <= 1'b1;
    sp_load <= 1'b0;
    sp_value <= 16'h3002;
    cond_flags <= 8'h00;
    pc = 16'h0000;
    i_crs_mem_model.mem[0] = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    check("ip_reset", IP_RESET, instruction_pointer);
    check("sp_reset", SP_RESET, stack_top_pointer);
    @(posedge clk);
    rst <= 1'b0;
    sp_load <= 1'b1;
    @(posedge clk);
    sp_load <= 1'b0;
    pc = 16'h0000;
    // Counting starts one cycle into this fetch, so the four-cycle filler shows three
    run(8'h00, 8'h00, 8'h00, 8'h00, 3, 16'h0001, 16'h3002);
  endtask

  task automatic test_call;
    run(8'h00, OP_CALL, 8'h35, 8'h21, TOT_CALL, 16'h2135, 16'h3000);
    check_stack(16'h3000, 16'h0004);
  endtask

  task automatic test_cc_false;
    for (int c = 0; c < 8; c++) begin
      ra = pc + 16'h0003;
      run(cflags(3'(c), 1'b0), {2'b11, 3'(c), 3'b100}, 8'h77, 8'h66, TOT_CALL_SKIP, ra,
        16'h3000);
      run(cflags(3'(c), 1'b0), {2'b11, 3'(c), 3'b000}, 8'h00, 8'h00, TOT_RET_SKIP,
        ra + 16'h0001, 16'h3000);
    end
  endtask

  task automatic test_cc_true;
    for (int c = 0; c < 8; c++) begin
      ra = pc + 16'h0003;
      tg = pc + 16'h0100;
      run(cflags(3'(c), 1'b1), {2'b11, 3'(c), 3'b100}, tg[7:0], tg[15:8], TOT_CALL, tg,
        16'h2ffe);
      check_stack(16'h2ffe, ra);
      run(cflags(3'(c), 1'b1), {2'b11, 3'(c), 3'b000}, 8'h00, 8'h00, TOT_RET_CC, ra,
        16'h3000);
    end
  endtask

  task automatic test_ret;
    run(8'hff, OP_RET, 8'h00, 8'h00, TOT_RET, 16'h0004, 16'h3002);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Whole run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  initial begin
    test_reset();
    test_call();
    test_cc_false();
    test_cc_true();
    test_ret();
    give_verdict();
  end
endmodule // call_return_sequencer_test

`default_nettype wire

// file: sim/crs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module crs_mem_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Released data bus shows the inverse of the last byte so stale reads show up
  always_comb mem_rdata = mem_rd ? mem[mem_addr] : ~last;

  // Stack bytes are kept exactly where written and read back from there
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) last <= mem[mem_addr];
  end
endmodule // crs_mem_model

`default_nettype wire
